// [verilog/dspsd_datapath.sv]
`timescale 1ns/1ns
`include "dspsd_defs.svh"
module dspsd_datapath
    import dspsd_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // issue
    input  wire logic        issue,
    input  wire dspsd_op_e   op,
    input  wire logic [31:0] srcA,
    input  wire logic [31:0] srcB,
    input  wire logic [31:0] destIn,
    input  wire logic [4:0]  shAmt,
    input  wire logic        shFromReg,
    input  wire logic        satEn,
    input  wire logic        roundEn,
    input  wire logic        variantHi,
    input  wire logic        variantAlt,
    input  wire logic        fracForm,
    input  wire logic [1:0]  cmpKind,
    input  wire logic [1:0]  accSel,
    input  wire logic [5:0]  sizeField,
    input  wire logic        decPos,
    input  wire logic [9:0]  immVal,
    input  wire logic [5:0]  ctrlMask,
    input  wire logic        extension_enable_bit,
    // results
    output logic [31:0]      result,
    output logic             resultValid,
    output logic             illegalOp,
    output logic [31:0]      dsp_status_control,
    output logic [63:0]      accOut,
    output logic             extension_present_bit
);
    dspsd_state_s st_reg;       // registered state
    dspsd_state_s st_next;      // next state
    // field mask expanded from six mask bits
    function automatic logic [31:0] fieldMask(input logic [5:0] m);
        fieldMask = {4'h0, {4{m[4]}}, {8{m[3]}}, 1'b0, m[5], m[2], {6{m[1]}}, 1'b0, {6{m[0]}}};
    endfunction
    // signed saturation of 33 bits to 32
    function automatic logic [32:0] sat32(input logic [32:0] v);
        if (v[32] != v[31]) sat32 = {1'b1, v[32] ? 32'h8000_0000 : 32'h7fff_ffff};
        else sat32 = {1'b0, v[31:0]};
    endfunction
    // signed saturation of 17 bits to 16
    function automatic logic [16:0] sat16(input logic [16:0] v);
        if (v[16] != v[15]) sat16 = {1'b1, v[16] ? 16'h8000 : 16'h7fff};
        else sat16 = {1'b0, v[15:0]};
    endfunction
    logic [4:0] sh;              // shift amount chosen
    logic [63:0] accCur;         // selected accumulator
    logic [6:0] pos;             // current position field
    always_comb begin
        sh = shFromReg ? srcB[4:0] : shAmt;
        accCur = st_reg.acc[accSel];
        pos = {1'b0, st_reg.ctrl[5:0]};
    end
    // one combinational step per issued op
    always_comb begin
        logic [32:0] w;
        logic [16:0] h;
        logic [16:0] hs;        // saturated halfword with clamp flag
        logic [8:0]  b;
        logic [63:0] t;
        logic [31:0] r;
        logic [7:0]  ouf;
        logic        ovf;
        logic [31:0] msk;
        w = '0;
        h = '0;
        hs = '0;
        b = '0;
        t = '0;
        r = '0;
        ouf = 8'h00;
        ovf = 1'b0;
        msk = '0;
        st_next = st_reg;
        st_next.resValid = 1'b0;
        st_next.illegal = 1'b0;
        if (issue && !extension_enable_bit && op != OP_NOP) begin
            st_next.illegal = 1'b1;
        end else if (issue) begin
            case (op)
                OP_ADDQS_W, OP_SUBQS_W, OP_ABSQS_W: begin
                    if (op == OP_ADDQS_W) w = {srcA[31], srcA} + {srcB[31], srcB};
                    else if (op == OP_SUBQS_W) w = {srcA[31], srcA} - {srcB[31], srcB};
                    else w = srcA[31] ? 33'h0 - {srcA[31], srcA} : {1'b0, srcA};
                    w = sat32(w);
                    r = w[31:0];
                    ouf[`DSPSD_OUF_ADD] = w[32];
                end
                OP_ADDSC, OP_ADDWC: begin
                    w = {1'b0, srcA} + {1'b0, srcB} + {32'h0, op == OP_ADDWC && st_reg.ctrl[13]};
                    r = w[31:0];
                    if (op == OP_ADDSC) st_next.ctrl[`DSPSD_CARRY_BIT] = w[32];
                    else if ({srcA[31], srcA} + {srcB[31], srcB} + {32'h0, st_reg.ctrl[13]}
                             != {w[31], w[31:0]}) ouf[`DSPSD_OUF_ADD] = 1'b1;
                end
                OP_ADD_PH, OP_SUB_PH, OP_ABS_PH: begin
                    for (int i = 0; i < 2; i++) begin
                        if (op == OP_ADD_PH) h = {srcA[16*i+15], srcA[16*i+:16]} + {srcB[16*i+15], srcB[16*i+:16]};
                        else if (op == OP_SUB_PH) h = {srcA[16*i+15], srcA[16*i+:16]} - {srcB[16*i+15], srcB[16*i+:16]};
                        else h = srcA[16*i+15] ? 17'h0 - {1'b1, srcA[16*i+:16]} : {1'b0, srcA[16*i+:16]};
                        hs = sat16(h);
                        ovf = hs[16];
                        r[16*i+:16] = (satEn || op == OP_ABS_PH) ? hs[15:0] : h[15:0];
                        ouf[`DSPSD_OUF_ADD] = ouf[`DSPSD_OUF_ADD] | ovf;
                    end
                end
                OP_ADD_QB, OP_SUB_QB: begin
                    for (int i = 0; i < 4; i++) begin
                        b = (op == OP_ADD_QB) ? {1'b0, srcA[8*i+:8]} + {1'b0, srcB[8*i+:8]}
                                              : {1'b0, srcA[8*i+:8]} - {1'b0, srcB[8*i+:8]};
                        r[8*i+:8] = (satEn && b[8]) ? ((op == OP_ADD_QB) ? 8'hff : 8'h00) : b[7:0];
                        ouf[`DSPSD_OUF_ADD] = ouf[`DSPSD_OUF_ADD] | b[8];
                    end
                end
                OP_BYTE_SUM: r = {22'h0, {2'h0, srcA[7:0]} + {2'h0, srcA[15:8]}
                                  + {2'h0, srcA[23:16]} + {2'h0, srcA[31:24]}};
                OP_SHLL_W: begin
                    t = {{32{srcA[31]}}, srcA} << sh;
                    ovf = t[63:31] != {33{t[31]}} && t[63:31] != 33'h0;
                    ovf = (t[62:31] != {32{srcA[31]}});
                    r = (satEn && ovf) ? (srcA[31] ? 32'h8000_0000 : 32'h7fff_ffff) : t[31:0];
                    ouf[`DSPSD_OUF_SHL] = ovf;
                end
                OP_SHRA_W: begin
                    t = {{32{srcA[31]}}, srcA};
                    if (roundEn && sh != 5'h0) t = t + (64'h1 << (sh - 5'h1));
                    t = $signed(t) >>> sh;
                    r = t[31:0];
                end
                OP_SHLL_PH, OP_SHRA_PH: begin
                    for (int i = 0; i < 2; i++) begin
                        t = {{48{srcA[16*i+15]}}, srcA[16*i+:16]};
                        if (op == OP_SHLL_PH) begin
                            t = t << sh[3:0];
                            ovf = t[31:15] != {17{srcA[16*i+15]}};
                            r[16*i+:16] = (satEn && ovf) ? (srcA[16*i+15] ? 16'h8000 : 16'h7fff) : t[15:0];
                            ouf[`DSPSD_OUF_SHL] = ouf[`DSPSD_OUF_SHL] | ovf;
                        end else begin
                            if (roundEn && sh[3:0] != 4'h0) t = t + (64'h1 << (sh[3:0] - 4'h1));
                            t = $signed(t) >>> sh[3:0];
                            r[16*i+:16] = t[15:0];
                        end
                    end
                end
                OP_SHLL_QB, OP_SHRL_QB: begin
                    for (int i = 0; i < 4; i++) begin
                        r[8*i+:8] = (op == OP_SHLL_QB) ? srcA[8*i+:8] << sh[2:0] : srcA[8*i+:8] >> sh[2:0];
                        if (op == OP_SHLL_QB && (({8'h0, srcA[8*i+:8]} << sh[2:0]) >> 8) != 16'h0)
                            ouf[`DSPSD_OUF_SHL] = 1'b1;
                    end
                end
                OP_CMP_PH: begin
                    for (int i = 0; i < 2; i++) begin
                        st_next.ctrl[24+i] = (cmpKind == 2'h0) ? srcA[16*i+:16] == srcB[16*i+:16] :
                            (cmpKind == 2'h1) ? $signed(srcA[16*i+:16]) < $signed(srcB[16*i+:16]) :
                            $signed(srcA[16*i+:16]) <= $signed(srcB[16*i+:16]);
                    end
                end
                OP_CMP_QB, OP_CMPG_QB: begin
                    for (int i = 0; i < 4; i++) begin
                        r[i] = (cmpKind == 2'h0) ? srcA[8*i+:8] == srcB[8*i+:8] :
                            (cmpKind == 2'h1) ? srcA[8*i+:8] < srcB[8*i+:8] : srcA[8*i+:8] <= srcB[8*i+:8];
                    end
                    if (op == OP_CMP_QB) begin
                        st_next.ctrl[27:24] = r[3:0];
                        r = '0;
                    end
                end
                OP_HALFWORD_LANE_SELECT: for (int i = 0; i < 2; i++)
                    r[16*i+:16] = st_reg.ctrl[24+i] ? srcA[16*i+:16] : srcB[16*i+:16];
                OP_BYTE_LANE_SELECT: for (int i = 0; i < 4; i++)
                    r[8*i+:8] = st_reg.ctrl[24+i] ? srcA[8*i+:8] : srcB[8*i+:8];
                OP_PACK_SWAP: r = {srcA[15:0], srcB[31:16]};
                OP_EXP_Q15: r = {variantHi ? srcA[31:16] : srcA[15:0], 16'h0};
                OP_EXP_QB: begin
                    w[15:0] = variantAlt ? (variantHi ? {srcA[31:24], srcA[15:8]} : {srcA[23:16], srcA[7:0]})
                                         : (variantHi ? srcA[31:16] : srcA[15:0]);
                    r = fracForm ? {1'b0, w[15:8], 8'h0, w[7:0], 7'h0} : {8'h0, w[15:8], 8'h0, w[7:0]};
                end
                OP_RED_W2PH: begin
                    r = {srcA[31:16], srcB[31:16]};
                    if (roundEn) begin
                        w = {srcA[31], srcA} + 33'h8000;
                        ovf = w[32] != w[31];
                        r[31:16] = ovf ? 16'h7fff : w[31:16];
                        ouf[`DSPSD_OUF_SHL] = ovf;
                        w = {srcB[31], srcB} + 33'h8000;
                        r[15:0] = (w[32] != w[31]) ? 16'h7fff : w[31:16];
                        ouf[`DSPSD_OUF_SHL] = ouf[`DSPSD_OUF_SHL] | (w[32] != w[31]);
                    end
                end
                OP_RED_PH2QB: begin
                    for (int i = 0; i < 4; i++) begin
                        h[15:0] = (i < 2) ? srcB[16*(i%2)+:16] : srcA[16*(i%2)+:16];
                        if (!satEn) r[8*i+:8] = h[15:8];
                        else if (h[15]) begin
                            r[8*i+:8] = 8'h00;
                            ouf[`DSPSD_OUF_SHL] = 1'b1;
                        end else if (h[14:7] + 8'h1 > 8'hff || h[14:7] == 8'hff) begin
                            r[8*i+:8] = 8'hff;
                            ouf[`DSPSD_OUF_SHL] = 1'b1;
                        end else r[8*i+:8] = h[14:7] + {7'h0, h[6]};
                    end
                end
                OP_REPL_IMM: r = {2{{6{immVal[9]}}, immVal}};
                OP_HALFWORD_REPLICATE_IMM: r = {2{srcA[15:0]}};
                OP_REPL_QB: r = {4{srcA[7:0]}};
                OP_INSV: begin
                    msk = (st_reg.ctrl[12:7] >= 6'd32) ? 32'hffff_ffff : (32'h1 << st_reg.ctrl[12:7]) - 32'h1;
                    r = (destIn & ~(msk << pos[4:0])) | ((srcA & msk) << pos[4:0]);
                end
                OP_EXTP: begin
                    st_next.ctrl[`DSPSD_EFI_BIT] = pos < ({1'b0, sizeField} + 7'h1);
                    t = accCur >> (pos[5:0] - sizeField);
                    r = t[31:0] & ((32'h2 << sizeField[4:0]) - 32'h1);
                    if (decPos) st_next.ctrl[5:0] = st_reg.ctrl[5:0] - sizeField - 6'h1;
                end
                OP_SHIFT_FILL: begin
                    st_next.acc[accSel] = {accCur[31:0], srcA};
                    st_next.ctrl[5:0] = st_reg.ctrl[5:0] + `DSPSD_FILL_STEP;
                end
                OP_RDCTRL: r = st_reg.ctrl & fieldMask(ctrlMask);
                OP_WRCTRL: st_next.ctrl = (st_reg.ctrl & ~fieldMask(ctrlMask))
                                        | (srcA & fieldMask(ctrlMask));
                default: r = '0;
            endcase
            st_next.ctrl[23:16] = st_next.ctrl[23:16] | ouf;
            st_next.result = r;
            st_next.resValid = 1'b1;
        end
        st_next.ctrl[31:28] = 4'h0;
        st_next.ctrl[15] = 1'b0;
        st_next.ctrl[6] = 1'b0;
    end
    // state register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            extension_present_bit <= 1'b0;
        end else begin
            st_reg <= st_next;
            extension_present_bit <= 1'b1;
        end
    end
    // outputs straight from state
    always_comb begin
        result = st_reg.result;
        resultValid = st_reg.resValid;
        illegalOp = st_reg.illegal;
        dsp_status_control = st_reg.ctrl;
        accOut = st_reg.acc[0];
    end
endmodule

// [verilog/dspsd_defs.svh]
// Function
// - extract fail set when position below size plus one
// - carry add stores carry, carry-in add uses it
// - insert width from scount, position is lowest bit
// - extract position marks field's highest bit
// - decrementing extract lowers position by size plus one
// - shift-fill copies low to high, position plus 32
// - four 64-bit accumulators, two-bit select
// - presence bit reported; enable bit gates instructions
// - saturating word add, subtract, absolute value
// - halfword and byte lane arithmetic, byte unsigned
// - byte sum zero-extended to a word
// - shift amount immediate or register; saturating forms
// - rounding right shift adds half, keeps sign
// - replicate sign-extended ten-bit immediate or register
// - halfword compares write two condition bits
// - byte compares write four flags, lane order
// - pick chooses lanes by condition bits
// - pack swaps halfwords from two sources
// - halfword expand to upper sixteen bits
// - byte expand selects pairs, fractional or integer
// - word-to-halfword takes upper halves, rounding variant
// - halfword-to-byte keeps upper bits, saturating variant
// - overflow sets flag by operation class
// - control register field layout, others zero
// - masked control writes and masked reads
`ifndef DSPSD_DEFS_SVH
`define DSPSD_DEFS_SVH
`define DSPSD_POS_LSB       0
`define DSPSD_SCOUNT_LSB    7
`define DSPSD_CARRY_BIT     13
`define DSPSD_EFI_BIT       14
`define DSPSD_OUF_LSB       16
`define DSPSD_CCOND_LSB     24
`define DSPSD_OUF_ADD       4
`define DSPSD_OUF_MUL       5
`define DSPSD_OUF_SHL       6
`define DSPSD_OUF_SHX       7
`define DSPSD_CTRL_RESET    32'h0000_0000
`define DSPSD_FILL_STEP     6'h20
`endif

// [verilog/dspsd_pkg.sv]
package dspsd_pkg;
    // operation codes issued by the pipeline
    typedef enum logic [5:0] {
        OP_NOP, OP_ADDQS_W, OP_SUBQS_W, OP_ABSQS_W, OP_ADDSC, OP_ADDWC,
        OP_ADD_PH, OP_SUB_PH, OP_ABS_PH, OP_ADD_QB, OP_SUB_QB, OP_BYTE_SUM,
        OP_SHLL_W, OP_SHRA_W, OP_SHLL_PH, OP_SHRA_PH, OP_SHLL_QB, OP_SHRL_QB,
        OP_CMP_PH, OP_CMP_QB, OP_CMPG_QB, OP_HALFWORD_LANE_SELECT, OP_BYTE_LANE_SELECT, OP_PACK_SWAP,
        OP_EXP_Q15, OP_EXP_QB, OP_RED_W2PH, OP_RED_PH2QB, OP_REPL_IMM,
        OP_HALFWORD_REPLICATE_IMM, OP_REPL_QB, OP_INSV, OP_EXTP, OP_SHIFT_FILL,
        OP_RDCTRL, OP_WRCTRL
    } dspsd_op_e;
    // whole block state
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] result;
        logic        resValid;
        logic        illegal;
        logic [3:0][63:0] acc;
    } dspsd_state_s;
endpackage

// [dv/dspsd_pipe_model.sv]
`timescale 1ns/1ns
module dspsd_pipe_model (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // software request and status bit
    input  wire logic enReq,
    output logic      enBit
);
    // status enable bit, written by software before use
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) enBit <= 1'b0;
        else enBit <= enReq;
    end
endmodule

// [dv/dspsd_datapath_asserts.sv]
`timescale 1ns/1ns
module dspsd_datapath_asserts
    import dspsd_pkg::*;
(
    input wire logic mclk, reset_n, issue, extension_enable_bit,
    input wire dspsd_op_e op,
    input wire logic [31:0] srcA, srcB, result, dsp_status_control,
    input wire logic [1:0] accSel,
    input wire logic [9:0] immVal,
    input wire logic [5:0] ctrlMask,
    input wire logic resultValid, illegalOp, extension_present_bit,
    input wire logic [63:0] accOut
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // issue-edge copies of operands and control
    logic [31:0] pA, pB, pC, pk;
    logic [9:0] pI;
    wire ok = issue && extension_enable_bit;
    always_ff @(posedge mclk) begin
        pA <= srcA;
        pB <= srcB;
        pC <= dsp_status_control;
        pI <= immVal;
    end
    // expected byte pick from the old condition bits
    always_comb begin
        for (int i = 0; i < 4; i++) pk[8*i+:8] = pC[24+i] ? pA[8*i+:8] : pB[8*i+:8];
    end
    AST_VALID: assert property (ok && op != OP_NOP |=> resultValid)
        else $error("no result after issue");
    AST_ILLEGAL: assert property (issue && !extension_enable_bit && op != OP_NOP
        |=> illegalOp && !resultValid && $stable(dsp_status_control))
        else $error("disabled issue took effect");
    AST_RSVD: assert property (dsp_status_control[31:28] == 4'h0 &&
        dsp_status_control[15] == 1'b0 && dsp_status_control[6] == 1'b0)
        else $error("reserved control bits set");
    AST_BSUM: assert property (ok && op == OP_BYTE_SUM |=> result == 32'(pA[7:0])
        + 32'(pA[15:8]) + 32'(pA[23:16]) + 32'(pA[31:24])) else $error("byte sum wrong");
    AST_PICK: assert property (ok && op == OP_BYTE_LANE_SELECT |=> result == pk)
        else $error("byte pick wrong");
    AST_FILL: assert property (ok && op == OP_SHIFT_FILL && accSel == 2'h0 |=>
        accOut[63:32] == $past(accOut[31:0]) && dsp_status_control[5:0] == pC[5:0] + 6'h20)
        else $error("shift fill wrong");
    AST_REPL: assert property (ok && op == OP_REPL_IMM |=> result == {2{{6{pI[9]}}, pI}})
        else $error("replicate wrong");
    AST_RDMASK: assert property (ok && op == OP_RDCTRL && ctrlMask == 6'h01
        |=> result == {26'h0, pC[5:0]}) else $error("masked read wrong");
    AST_PRESENT: assert property ($past(reset_n) |-> extension_present_bit)
        else $error("presence bit low");
endmodule
bind dspsd_datapath dspsd_datapath_asserts u_chk (.mclk, .reset_n, .issue,
    .extension_enable_bit, .op, .srcA, .srcB, .result, .dsp_status_control, .accSel,
    .immVal, .ctrlMask, .resultValid, .illegalOp, .extension_present_bit, .accOut);

// [dv/dspsd_datapath_bench.sv]
`timescale 1ns/1ns
module dspsd_datapath_bench;
    import dspsd_pkg::*;
    // stimulus
    logic mclk = 1'b0, reset_n = 1'b0, issue = 1'b0, enReq = 1'b0, satEn = 1'b0;
    logic decPos = 1'b0;
    dspsd_op_e op = OP_NOP, o;
    logic [31:0] srcA = 32'h0, srcB = 32'h0, destIn = 32'h0, a, b, e, mc = 32'h0;
    logic [31:0] rnd = 32'h4, result, ctl;
    logic [4:0] shAmt = 5'h0;
    logic [1:0] cmpKind = 2'h0, accSel = 2'h0;
    logic [5:0] sizeField = 6'h0, ctrlMask = 6'h0;
    logic [9:0] immVal = 10'h0;
    logic resultValid, illegalOp, enBit, present;
    logic [63:0] accOut;
    longint v, w;
    int fail_count = 0, n_tests = 0;
    always #25 mclk = ~mclk;
    dspsd_pipe_model i_pipe (.mclk, .reset_n, .enReq, .enBit);
    dspsd_datapath i_dut (.mclk, .reset_n, .issue, .op, .srcA, .srcB, .destIn, .shAmt,
        .shFromReg(1'b0), .satEn, .roundEn(1'b0), .variantHi(1'b0), .variantAlt(1'b0),
        .fracForm(1'b0), .cmpKind, .accSel, .sizeField, .decPos, .immVal, .ctrlMask,
        .extension_enable_bit(enBit), .result, .resultValid, .illegalOp,
        .dsp_status_control(ctl), .accOut, .extension_present_bit(present));
    // lfsr step for random operands
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // clamp to a signed word
    function automatic logic [31:0] sat(input longint x);
        return x > 64'sd2147483647 ? 32'h7fffffff : x < -64'sd2147483648 ? 32'h80000000 : 32'(x);
    endfunction
    // one issue at a falling edge, answer settled one cycle later
    task automatic run(input dspsd_op_e c, input logic [31:0] x, y);
        @(negedge mclk);
        op = c; srcA = x; srcB = y; issue = 1'b1; destIn = rnd; shAmt = rnd[4:0];
        @(negedge mclk);
        issue = 1'b0;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge mclk);
        @(negedge mclk) reset_n = 1'b1;
        chk("ctrl reset", ctl, 32'h0);
        run(OP_ADDQS_W, 32'h1, 32'h1);
        chk("refused", {illegalOp, resultValid, present}, 3'b101);
        enReq = 1'b1;
        $display("refusal test done");
        // saturating word add, subtract, absolute value
        for (int k = 0; k < 9; k++) begin
            a = k < 3 ? 32'h80000000 : k < 6 ? 32'h7fffffff : rnd;
            b = k < 3 ? 32'h1 : k < 6 ? 32'hffffffff : nx(rnd);
            rnd = nx(b);
            o = k % 3 == 0 ? OP_ADDQS_W : k % 3 == 1 ? OP_SUBQS_W : OP_ABSQS_W;
            v = $signed(a);
            w = $signed(b);
            v = k % 3 == 0 ? v + w : k % 3 == 1 ? v - w : (v < 0 ? -v : v);
            e = sat(v);
            if (e != 32'(v)) mc[20] = 1'b1;
            run(o, a, b);
            chk("sat word", result, e);
            chk("add flag", ctl, mc);
        end
        // byte add, wrapping then saturating
        for (int s = 0; s < 2; s++) begin
            satEn = s[0]; a = rnd; b = nx(rnd); rnd = nx(b);
            for (int i = 0; i < 4; i++) begin
                w = a[8*i+:8] + b[8*i+:8];
                e[8*i+:8] = (s == 1 && w > 255) ? 8'hff : w[7:0];
                if (w > 255) mc[20] = 1'b1;
            end
            run(OP_ADD_QB, a, b);
            chk("byte add", result, e);
            chk("byte flag", ctl, mc);
        end
        satEn = 1'b0;
        // carry chain
        run(OP_ADDSC, 32'hffffffff, 32'h2);
        mc[13] = 1'b1;
        chk("carry out", {result, ctl}, {32'h1, mc});
        run(OP_ADDWC, 32'h5, 32'h6);
        chk("carry in", result, 32'hc);
        ctrlMask = 6'h3f; mc = 32'h0;
        run(OP_WRCTRL, 32'h0, 32'h0);
        chk("ctrl clear", ctl, mc);
        $display("arithmetic tests done");
        // condition bits, masked read, pick
        ctrlMask = 6'h10; a = rnd; rnd = nx(rnd);
        run(OP_WRCTRL, a, 32'h0);
        mc[27:24] = a[27:24];
        run(OP_RDCTRL, 32'h0, 32'h0);
        chk("masked rw", {result, ctl}, {mc & 32'h0f000000, mc});
        a = rnd; b = nx(rnd); rnd = nx(b);
        for (int i = 0; i < 4; i++) e[8*i+:8] = mc[24+i] ? a[8*i+:8] : b[8*i+:8];
        run(OP_BYTE_LANE_SELECT, a, b);
        chk("pick", result, e);
        // byte compares to a register, every kind
        for (int k = 0; k < 3; k++) begin
            cmpKind = 2'(k); a = rnd; b = nx(rnd); b[31:16] = a[31:16]; rnd = b;
            e = 32'h0;
            for (int i = 0; i < 4; i++) begin
                w = a[8*i+:8];
                v = b[8*i+:8];
                e[i] = k == 0 ? w == v : k == 1 ? w < v : w <= v;
            end
            run(OP_CMPG_QB, a, b);
            chk("byte cmp", result, e);
        end
        // replicate immediate at both sign extremes
        for (int j = 0; j < 2; j++) begin
            immVal = j ? 10'h200 : 10'h1ff;
            run(OP_REPL_IMM, 32'h0, 32'h0);
            chk("replicate", result, {2{{6{immVal[9]}}, immVal}});
        end
        $display("lane tests done");
        // extract with too few bits, then with enough
        ctrlMask = 6'h01; decPos = 1'b1; sizeField = 6'h07;
        for (int k = 0; k < 2; k++) begin
            a = k ? 32'h14 : 32'h05;
            run(OP_WRCTRL, a, 32'h0);
            mc[5:0] = a[5:0];
            run(OP_EXTP, 32'h0, 32'h0);
            mc[14] = a[5:0] < 6'h08;
            chk("extract fail", ctl[14], mc[14]);
        end
        mc[5:0] = 6'h0c;
        chk("pos step", ctl, mc);
        // fill accumulator zero, other selector leaves it alone
        a = rnd; b = nx(rnd); rnd = nx(b);
        run(OP_SHIFT_FILL, a, 32'h0);
        mc[5:0] = 6'h2c;
        chk("fill pos", ctl, mc);
        run(OP_SHIFT_FILL, b, 32'h0);
        accSel = 2'h1;
        run(OP_SHIFT_FILL, rnd, 32'h0);
        chk("fill acc", accOut, {a, b});
        $display("accumulator tests done");
        summarize();
    end
endmodule
